/* verilog/lbf_pkg.sv */
// Shared constants and types of the strip hit latency buffer.
// Assumes a single 40 MHz reference clock for all logic.
package lbf_pkg;
  localparam int NUM_CH = 128;
  localparam int STRIP_W = 7;
  localparam int AMP_W = 4;
  localparam int TS_W = 10;
  localparam int CHIP_W = 4;
  localparam int WORD_W = 16;
  localparam int HDR_SPARE_W = 5;
  localparam logic [AMP_W-1:0] AMP_MAX = 4'hf;
  localparam logic WT_HIT = 1'b0;
  localparam logic WT_TS = 1'b1;

  // Latency buffer and output FIFO sizes
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
  localparam int PTR_W = MEM_AW + 1;
  localparam int FIFO_DEPTH = 32;
  localparam int HIST_W = 16;
  localparam int HIST_AW = 4;
  localparam logic [15:0] OVF_MAX = 16'hffff;

  // Timing: time-stamp ticks come from a phase accumulator in ns
  localparam int REF_PERIOD_NS = 25;
  localparam int TS_PERIOD_NS = 30;
  localparam int PH_W = 6;
  localparam logic [PH_W-1:0] PH_STEP = PH_W'(REF_PERIOD_NS);
  localparam logic [PH_W-1:0] PH_WRAP = PH_W'(TS_PERIOD_NS);
  localparam int LATENCY_NS = 6000;
  localparam int LAT_DEFAULT_TICKS = LATENCY_NS / TS_PERIOD_NS;
  localparam int TRIG_GAP_NS = 70;
  localparam int TRIG_GAP_CYC = (TRIG_GAP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

  typedef struct packed {
    logic [CHIP_W-1:0] chip;
    logic [STRIP_W-1:0] strip;
    logic [AMP_W-1:0] amp;
    logic [TS_W-1:0] ts;
  } lbf_rec_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'h0,
    RS_DECIDE = 2'h1,
    RS_HDR = 2'h3,
    RS_HIT = 2'h2
  } lbf_rd_state_t;

  function automatic logic [WORD_W-1:0] lbf_hit_word(input lbf_rec_t r);
    lbf_hit_word = {WT_HIT, r.chip, r.strip, r.amp};
  endfunction

  function automatic logic [WORD_W-1:0] lbf_ts_word(input logic [TS_W-1:0] ts);
    lbf_ts_word = {WT_TS, {HDR_SPARE_W{1'b0}}, ts};
  endfunction
endpackage

/* verilog/lbf_mem_if.sv */
// Carrier between the hit path and the latency memory.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface lbf_mem_if;
  import lbf_pkg::*;
  logic wr_en;
  logic [MEM_AW-1:0] wr_addr;
  logic [MEM_AW-1:0] rd_addr;
  lbf_rec_t wr_data;
  lbf_rec_t rd_data;
  modport ctrl(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* verilog/lbf_hit_mem.sv */
// Latency memory: one write port, one read port with registered data.
// Assumes the controller keeps the read address stable while it waits.
`timescale 1ns/1ps
module lbf_hit_mem (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  lbf_mem_if.mem bus
);
  import lbf_pkg::*;

  lbf_rec_t store [MEM_DEPTH];
  lbf_rec_t rd_reg;

  always_ff @(posedge ref_clk) begin
    if (ce && bus.wr_en) begin
      store[bus.wr_addr] <= bus.wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_reg <= '0;
    end else if (ce) begin
      rd_reg <= store[bus.rd_addr];
    end
  end

  assign bus.rd_data = rd_reg;
endmodule

/* verilog/lbf_fifo.sv */
// Output FIFO with valid/ready on both sides and a registered output stage.
// Assumes DEPTH is a power of two.
`timescale 1ns/1ps
module lbf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic ov_reg, ov_next;
  logic [WIDTH-1:0] od_reg, od_next;
  logic push, pop;

  always_comb begin
    in_ready = (cnt_reg != CW'(DEPTH));
    push = in_valid && in_ready;
    pop = (cnt_reg != '0) && (!ov_reg || out_ready);
    wp_next = push ? AW'(wp_reg + 1'b1) : wp_reg;
    rp_next = pop ? AW'(rp_reg + 1'b1) : rp_reg;
    cnt_next = CW'(cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    ov_next = pop ? 1'b1 : (out_ready ? 1'b0 : ov_reg);
    od_next = pop ? store[rp_reg] : od_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      store[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      ov_reg <= 1'b0;
      od_reg <= '0;
    end else if (ce) begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
      cnt_reg <= cnt_next;
      ov_reg <= ov_next;
      od_reg <= od_next;
    end
  end

  assign out_valid = ov_reg;
  assign out_data = od_reg;
endmodule

/* verilog/lbf_latency_buffer.sv */
// Digital hit path of a 128-channel strip readout: capture, latency buffer, readout.
// Assumes discriminator and trigger inputs are asynchronous pins; latency and
// push mode come from configuration logic on ref_clk and are held steady.
`timescale 1ns/1ps
module lbf_latency_buffer (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic [lbf_pkg::NUM_CH-1:0] disc_in,
  input wire logic trig_in,
  input wire logic [lbf_pkg::CHIP_W-1:0] chip_id_in,
  input wire logic push_mode,
  input wire logic [lbf_pkg::TS_W-1:0] lat_ticks,
  input wire logic dout_ready,
  output logic dout_valid,
  output logic [lbf_pkg::WORD_W-1:0] dout_data,
  output logic [15:0] overflow_count
);
  import lbf_pkg::*;

  function automatic logic [STRIP_W:0] first_set(input logic [NUM_CH-1:0] v);
    first_set = '0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_set = {1'b1, STRIP_W'(k)};
      end
    end
  endfunction

  // Time-stamp clock
  logic [PH_W-1:0] ph_reg, ph_next, ph_sum;
  logic [TS_W-1:0] ts_reg, ts_next;
  logic ts_tick;

  always_comb begin
    ph_sum = PH_W'(ph_reg + PH_STEP);
    ts_tick = (ph_sum >= PH_WRAP);
    ph_next = ts_tick ? PH_W'(ph_sum - PH_WRAP) : ph_sum;
    ts_next = ts_tick ? TS_W'(ts_reg + 1'b1) : ts_reg;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_reg <= '0;
      ts_reg <= '0;
    end else if (ce) begin
      ph_reg <= ph_next;
      ts_reg <= ts_next;
    end
  end

  // Input synchronisers and strap capture
  logic [NUM_CH-1:0] d1_reg, d2_reg, d3_reg;
  logic t1_reg, t2_reg, t3_reg;
  logic chip_cap_reg;
  logic [CHIP_W-1:0] chip_reg, chip_next;

  always_comb begin
    chip_next = chip_cap_reg ? chip_reg : chip_id_in;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      d1_reg <= '0;
      d2_reg <= '0;
      d3_reg <= '0;
      t1_reg <= 1'b0;
      t2_reg <= 1'b0;
      t3_reg <= 1'b0;
      chip_cap_reg <= 1'b0;
      chip_reg <= '0;
    end else if (ce) begin
      d1_reg <= disc_in;
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
      t1_reg <= trig_in;
      t2_reg <= t1_reg;
      t3_reg <= t2_reg;
      chip_cap_reg <= 1'b1;
      chip_reg <= chip_next;
    end
  end

  // Trigger history: bit j marks a trigger j ticks ago
  logic trig_rise;
  logic [HIST_W-1:0] hist_reg, hist_next;

  always_comb begin
    trig_rise = t2_reg && !t3_reg;
    if (ts_tick) begin
      hist_next = {hist_reg[HIST_W-2:0], trig_rise};
    end else begin
      hist_next = {hist_reg[HIST_W-1:1], hist_reg[0] | trig_rise};
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_reg <= '0;
    end else if (ce) begin
      hist_reg <= hist_next;
    end
  end

  // Per-channel pulse-width measurement
  logic [AMP_W-1:0] amp_reg [NUM_CH];
  logic [AMP_W-1:0] amp_next [NUM_CH];
  logic [TS_W-1:0] lead_reg [NUM_CH];
  logic [TS_W-1:0] lead_next [NUM_CH];
  logic pend_reg [NUM_CH];
  logic pend_next [NUM_CH];
  logic [NUM_CH-1:0] pend_vec;
  logic grant;
  logic [STRIP_W-1:0] grant_idx;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    always_comb begin
      amp_next[i] = amp_reg[i];
      lead_next[i] = lead_reg[i];
      pend_next[i] = pend_reg[i];
      if (grant && grant_idx == STRIP_W'(i)) begin
        pend_next[i] = 1'b0;
      end
      if (d2_reg[i] && !d3_reg[i]) begin
        amp_next[i] = '0;
        lead_next[i] = ts_reg;
      end else if (d2_reg[i] && ts_tick && amp_reg[i] != AMP_MAX) begin
        amp_next[i] = AMP_W'(amp_reg[i] + 1'b1);
      end
      if (!d2_reg[i] && d3_reg[i]) begin
        pend_next[i] = 1'b1;
      end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        amp_reg[i] <= '0;
        lead_reg[i] <= '0;
        pend_reg[i] <= 1'b0;
      end else if (ce) begin
        amp_reg[i] <= amp_next[i];
        lead_reg[i] <= lead_next[i];
        pend_reg[i] <= pend_next[i];
      end
    end
  end

  // Arbitration into the latency memory
  lbf_mem_if mem_bus ();
  lbf_hit_mem u_mem (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .bus(mem_bus)
  );

  logic [PTR_W-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
  logic [15:0] ovf_reg, ovf_next;
  logic full, empty;
  lbf_rec_t rec_wr;

  always_comb begin
    for (int k = 0; k < NUM_CH; k++) begin
      pend_vec[k] = pend_reg[k];
    end
    {grant, grant_idx} = first_set(pend_vec);
    empty = (wr_ptr_reg == rd_ptr_reg);
    full = (wr_ptr_reg[MEM_AW] != rd_ptr_reg[MEM_AW]) &&
           (wr_ptr_reg[MEM_AW-1:0] == rd_ptr_reg[MEM_AW-1:0]);
    rec_wr = '{chip: chip_reg, strip: grant_idx, amp: amp_reg[grant_idx],
               ts: lead_reg[grant_idx]};
    wr_ptr_next = wr_ptr_reg;
    ovf_next = ovf_reg;
    if (grant && !full) begin
      wr_ptr_next = PTR_W'(wr_ptr_reg + 1'b1);
    end else if (grant && ovf_reg != OVF_MAX) begin
      ovf_next = 16'(ovf_reg + 1'b1);
    end
  end

  assign mem_bus.wr_en = grant && !full;
  assign mem_bus.wr_addr = wr_ptr_reg[MEM_AW-1:0];
  assign mem_bus.wr_data = rec_wr;
  assign mem_bus.rd_addr = rd_ptr_reg[MEM_AW-1:0];

  // Readout engine
  lbf_rd_state_t rd_state_reg, rd_state_next;
  lbf_rec_t rec_rd;
  logic [TS_W-1:0] age, lag;
  logic [TS_W-1:0] last_ts_reg, last_ts_next;
  logic last_valid_reg, last_valid_next;
  logic matured, expired, hist_hit, send;
  logic fifo_in_valid, fifo_in_ready;
  logic [WORD_W-1:0] fifo_in_data;

  always_comb begin
    rec_rd = mem_bus.rd_data;
    age = TS_W'(ts_reg - rec_rd.ts);
    lag = TS_W'(age - lat_ticks);
    matured = (age >= lat_ticks);
    // Drop only after the matching tick has passed (at once when lat_ticks is all ones), so a late trigger in it still counts
    expired = matured && (lag != '0 || lat_ticks == '1);
    hist_hit = (lag < TS_W'(HIST_W)) && hist_reg[lag[HIST_AW-1:0]];
    send = push_mode || (matured && hist_hit);
    rd_state_next = rd_state_reg;
    rd_ptr_next = rd_ptr_reg;
    last_ts_next = last_ts_reg;
    last_valid_next = last_valid_reg;
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    case (rd_state_reg)
      RS_IDLE: begin
        if (!empty) begin
          rd_state_next = RS_DECIDE;
        end
      end
      RS_DECIDE: begin
        if (send) begin
          if (last_valid_reg && last_ts_reg == rec_rd.ts) begin
            rd_state_next = RS_HIT;
          end else begin
            rd_state_next = RS_HDR;
          end
        end else if (expired) begin
          rd_ptr_next = PTR_W'(rd_ptr_reg + 1'b1);
          rd_state_next = RS_IDLE;
        end
      end
      RS_HDR: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = lbf_ts_word(rec_rd.ts);
        if (fifo_in_ready) begin
          last_ts_next = rec_rd.ts;
          last_valid_next = 1'b1;
          rd_state_next = RS_HIT;
        end
      end
      RS_HIT: begin
        fifo_in_valid = 1'b1;
        fifo_in_data = lbf_hit_word(rec_rd);
        if (fifo_in_ready) begin
          rd_ptr_next = PTR_W'(rd_ptr_reg + 1'b1);
          rd_state_next = RS_IDLE;
        end
      end
      default: begin
        rd_state_next = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      ovf_reg <= '0;
      rd_state_reg <= RS_IDLE;
      last_ts_reg <= '0;
      last_valid_reg <= 1'b0;
    end else if (ce) begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      ovf_reg <= ovf_next;
      rd_state_reg <= rd_state_next;
      last_ts_reg <= last_ts_next;
      last_valid_reg <= last_valid_next;
    end
  end

  lbf_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(dout_valid),
    .out_ready(dout_ready),
    .out_data(dout_data)
  );

  assign overflow_count = ovf_reg;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_ts_step: assert property ((ce && ts_tick) |=> ts_reg == TS_W'($past(ts_reg) + 1'b1))
    else $error("time stamp did not advance on tick");
  a_tick_gap: assert property ((ce && !ts_tick) ##1 ce |-> ts_tick)
    else $error("two ref cycles in a row without a time-stamp tick");
  a_drop_full: assert property ((ce && grant && full && ovf_reg != OVF_MAX) |=>
      wr_ptr_reg == $past(wr_ptr_reg) && ovf_reg == 16'($past(ovf_reg) + 1'b1))
    else $error("hit into full buffer not dropped and counted");
  a_record_store: assert property ((ce && grant && !full) |=>
      wr_ptr_reg == PTR_W'($past(wr_ptr_reg) + 1'b1) && !empty)
    else $error("granted hit not stored");
  a_drop_late: assert property ((ce && rd_state_reg == RS_DECIDE && !push_mode && expired
      && !hist_hit) |=> rd_state_reg == RS_IDLE && rd_ptr_reg == PTR_W'($past(rd_ptr_reg) + 1'b1))
    else $error("untriggered record not dropped");
  a_send_trig: assert property ((ce && rd_state_reg == RS_DECIDE && matured && hist_hit) |=>
      rd_state_reg inside {RS_HDR, RS_HIT})
    else $error("triggered record not sent");
  a_wait_latency: assert property ((ce && rd_state_reg == RS_DECIDE && !push_mode && !matured)
      |=> rd_state_reg == RS_DECIDE && $stable(rd_ptr_reg))
    else $error("record left buffer before latency");
  a_push_send: assert property ((ce && rd_state_reg == RS_DECIDE && push_mode) |=>
      rd_state_reg inside {RS_HDR, RS_HIT})
    else $error("push mode did not send record");
  a_hdr_first: assert property ((rd_state_reg == RS_HIT) |->
      last_valid_reg && last_ts_reg == rec_rd.ts)
    else $error("hit word sent without its time-stamp word");
endmodule

/* test/lbf_rx_model.sv */
// Receiver board model: takes every word of the output stream into a queue.
// Assumes words move on rising ref_clk edges with valid and ready both high.
`timescale 1ns/1ps
module lbf_rx_model (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [1:0] stall_mode,
  input wire logic dout_valid,
  input wire logic [lbf_pkg::WORD_W-1:0] dout_data,
  output logic dout_ready
);
  import lbf_pkg::*;
  logic [15:0] lfsr_reg;
  logic [WORD_W-1:0] words[$];

  // Mode 0 always ready, 1 random stalls, 2 held off
  initial begin
    dout_ready = 1'b0;
    lfsr_reg = 16'hb0a5;
    forever begin
      @(posedge ref_clk);
      if (reset_n && dout_valid && dout_ready) begin
        words.push_back(dout_data);
      end
      lfsr_reg = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
      #2;
      dout_ready = (stall_mode == 2'h0) || (stall_mode == 2'h1 && lfsr_reg[0]);
    end
  end
endmodule

/* test/strip_hit_latency_buffer_tb_top.sv */
// Testbench top: drives strip hits and triggers, checks the sparse output stream.
// Assumes the receiver model keeps every accepted word in its queue.
`timescale 1ns/1ps
module strip_hit_latency_buffer_tb_top;
  import lbf_pkg::*;
  localparam logic [CHIP_W-1:0] CHIP_VAL = 4'h9;
  logic ref_clk, reset_n, trig_in, push_mode, dout_ready, dout_valid;
  logic [NUM_CH-1:0] disc_in;
  logic [CHIP_W-1:0] chip_id_in;
  logic [TS_W-1:0] lat_ticks;
  logic [WORD_W-1:0] dout_data;
  logic [15:0] overflow_count;
  logic [1:0] stall_mode;
  logic [15:0] rnd_reg;
  int err_total, tests_run;

  lbf_latency_buffer uut (.ref_clk(ref_clk), .reset_n(reset_n), .ce(1'b1), .disc_in(disc_in),
    .trig_in(trig_in), .chip_id_in(chip_id_in), .push_mode(push_mode), .lat_ticks(lat_ticks),
    .dout_ready(dout_ready), .dout_valid(dout_valid), .dout_data(dout_data),
    .overflow_count(overflow_count));
  lbf_rx_model rx (.ref_clk(ref_clk), .reset_n(reset_n), .stall_mode(stall_mode),
    .dout_valid(dout_valid), .dout_data(dout_data), .dout_ready(dout_ready));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] next_rnd(input logic [15:0] s);
    next_rnd = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Amplitude bounds for a pulse of w clocks: 5 ticks per 6 clocks, one tick slack
  function automatic int amp_bound(input int w, input int up);
    int v;
    v = up ? (5 * w + 5) / 6 + 1 : (5 * w) / 6 - 1;
    amp_bound = (v > 15) ? 15 : v;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  task automatic pulse(input logic [NUM_CH-1:0] mask, input int w);
    disc_in = mask;
    cyc(w);
    disc_in = '0;
    cyc(3);
  endtask

  // Waits for 30 idle output cycles, bounded
  task automatic quiet();
    int idle;
    idle = 0;
    for (int k = 0; k < 800 && idle < 30; k++) begin
      cyc(1);
      idle = (dout_valid === 1'b1) ? 0 : idle + 1;
    end
    check({15'h0, idle >= 30}, 16'h1);
  endtask

  task automatic scan(input logic [NUM_CH-1:0] mask, input int lo, input int hi, input int n);
    logic [15:0] w;
    logic hdr;
    int hits;
    hdr = 1'b0;
    hits = 0;
    while (rx.words.size() > 0) begin
      w = rx.words.pop_front();
      if (w[15] === WT_TS) begin
        check({11'h0, w[14:10]}, 16'h0);
        hdr = 1'b1;
      end else begin
        hits++;
        check({15'h0, hdr}, 16'h1);
        check({12'h0, w[14:11]}, {12'h0, CHIP_VAL});
        check({15'h0, mask[w[10:4]]}, 16'h1);
        check({15'h0, w[3:0] >= lo && w[3:0] <= hi}, 16'h1);
      end
    end
    if (n < 0) begin
      check({15'h0, hits > 0}, 16'h1);
    end else begin
      check(16'(hits), 16'(n));
    end
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    conclude();
  end

  initial begin
    int ch, w;
    logic [NUM_CH-1:0] mask;
    err_total = 0;
    tests_run = 0;
    reset_n = 1'b0;
    trig_in = 1'b0;
    push_mode = 1'b1;
    disc_in = '0;
    chip_id_in = CHIP_VAL;
    lat_ticks = 10'h008;
    stall_mode = 2'h1;
    rnd_reg = 16'hb0a5;
    cyc(20);
    check({15'h0, dout_valid}, 16'h0);
    check(overflow_count, 16'h0);
    reset_n = 1'b1;
    cyc(1);
    check({15'h0, dout_valid}, 16'h0);
    // Push mode: edge channels saturated, then random strips and widths
    for (int i = 0; i < 10; i++) begin
      rnd_reg = next_rnd(rnd_reg);
      ch = (i == 0) ? 0 : (i == 1) ? 127 : int'(rnd_reg[6:0]);
      w = (i < 2) ? 40 : 2 + int'(rnd_reg[10:7]) % 12;
      mask = '0;
      mask[ch] = 1'b1;
      if (i > 4) begin
        mask[(ch + 37) % 128] = 1'b1;
      end
      pulse(mask, w);
      quiet();
      scan(mask, amp_bound(w, 0), amp_bound(w, 1), $countones(mask));
    end
    // Output held off: FIFO fills, buffer holds the rest
    stall_mode = 2'h2;
    mask = {80'h0, {48{1'b1}}};
    pulse(mask, 4);
    cyc(150);
    check({15'h0, dout_valid}, 16'h1);
    check(16'(rx.words.size()), 16'h0);
    stall_mode = 2'h1;
    quiet();
    scan(mask, amp_bound(4, 0), amp_bound(4, 1), 48);
    // Triggered mode without a trigger sends nothing
    push_mode = 1'b0;
    pulse(128'h20, 3);
    quiet();
    check(16'(rx.words.size()), 16'h0);
    // Staggered strips, two triggers 6 clocks apart, then a later strip
    // First trigger lands 10 ticks after strip 10 rises, so it must match
    lat_ticks = 10'h00a;
    mask = 128'h1c00;
    disc_in[10] = 1'b1;
    cyc(1);
    disc_in[11] = 1'b1;
    cyc(1);
    disc_in[12] = 1'b1;
    cyc(2);
    disc_in = '0;
    cyc(7);
    for (int t = 0; t < 2; t++) begin
      trig_in = 1'b1;
      cyc(3);
      trig_in = 1'b0;
      cyc(3);
    end
    pulse(128'h1 << 90, 3);
    quiet();
    scan(mask, 0, 15, -1);
    // Long latency, three full rounds: the last 128 records overflow
    lat_ticks = 10'h3ff;
    repeat (3) begin
      pulse('1, 3);
      cyc(137);
    end
    check(overflow_count, 16'h0080);
    check(16'(rx.words.size()), 16'h0);
    reset_n = 1'b0;
    cyc(20);
    check(overflow_count, 16'h0);
    reset_n = 1'b1;
    cyc(2);
    push_mode = 1'b1;
    lat_ticks = 10'h008;
    pulse(128'h1 << 64, 6);
    quiet();
    scan(128'h1 << 64, amp_bound(6, 0), amp_bound(6, 1), 1);
    conclude();
  end
endmodule
